// ### fe_line_codec.sv
// 100 Mb/s line coding path: three-level tx, rx decode, descrambler, 5b/4b, link monitor
// Function
// - scrambled tx bits go through nrzi, then three-level line code
// - a one bit changes the line level, a zero holds it
// - rx levels become nrzi bits, then nrz bits for the descrambler
// - rx logic takes one symbol per clock at the recovered rate
// - descrambler locks on idle; rx and tx data stay off until lock
// - after lock, sync is checked and reacquired on idle if lost
// - descrambled bits are aligned to 5-bit groups and mapped to nibbles
// - frames start only on start delimiter after idle; alignment held per frame
// - start delimiter pair is delivered as two 0101 nibbles, then data nibbles
// - conversion stops on end delimiter or two idle groups
// - start delimiter is 11000 then 10001
// - end delimiter is 01101 then 00111
// - bad start gives error and nibble 1110 until two idle groups
// - clock recovery tolerates jitter and ppm offset within limits; not done here, rx takes symbols already recovered upstream
// - standard link monitor; optional recovery state retries energy loss
// - optional link-down on descrambler sync loss
// - both link monitor add-ons are off after reset
// - signal detect compares an iir-filtered energy against thresholds
// - signal detect uses hysteresis
// - detector thresholds and listen time are programmable
//
// Chosen here: the AXI4-Lite slave port and the address map.
`include "line_defs.svh"
module fe_line_codec #(
    parameter logic [15:0] SYNC_LOSS_CYC = 16'(`US_TO_CYC(`SYNC_LOSS_US)),
    parameter logic [15:0] LINK_HOLD_CYC = 16'(`US_TO_CYC(`LINK_HOLD_US)),
    parameter logic [15:0] RECOVER_CYC   = 16'(`US_TO_CYC(`RECOVER_US))
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire line_pkg::axi_req_t   s_axi_req,
    output line_pkg::axi_rsp_t        s_axi_rsp,
    input  wire logic                 tx_bit,
    input  wire line_pkg::tl_level_t  rx_level,
    input  wire logic [7:0]           rx_energy,
    output line_pkg::tl_level_t       tx_level,
    output logic [3:0]                rx_nibble,
    output logic                      rx_dv,
    output logic                      rx_er,
    output logic                      link_up,
    output logic                      tx_data_ok
);
    import line_pkg::*;

    typedef struct packed {
        tl_level_t   tx_lvl;
        logic        tx_nrzi;
        logic        tx_last_pos;
        tl_level_t   rx_prev;
        logic        rx_nrzi;
        logic [10:0] lfsr;
        logic        locked;
        logic [4:0]  match_cnt;
        logic [5:0]  ones_cnt;
        logic [15:0] loss_cnt;
        logic [11:0] sr;
        rx_state_t   rst;
        logic [2:0]  bit_cnt;
        logic [4:0]  prev_grp;
        logic        have_prev;
        logic        pend_pre;
        logic [3:0]  nib;
        logic        dv;
        logic        er;
        link_state_t lnk;
        logic [15:0] lnk_cnt;
        logic        up;
        logic        tx_ok;
        logic [1:0]  ctrl;
        logic [7:0]  sd_on;
        logic [7:0]  sd_off;
        logic [15:0] sd_listen;
        logic        aw_have;
        logic        w_have;
        logic [7:0]  aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        axi_rsp_t    rsp;
    } st_t;

    st_t st;
    st_t nx;
    logic sig_det;

    assign s_axi_rsp  = st.rsp;
    assign tx_level   = st.tx_lvl;
    assign rx_nibble  = st.nib;
    assign rx_dv      = st.dv;
    assign rx_er      = st.er;
    assign link_up    = st.up;
    assign tx_data_ok = st.tx_ok;

    sig_energy_detect #(
        .W  (8),
        .K  (`SD_IIR_SHIFT),
        .LW (16)
    ) u_sd (
        .clk     (clk),
        .resetn  (resetn),
        .energy  (rx_energy),
        .on_thr  (st.sd_on),
        .off_thr (st.sd_off),
        .listen  (st.sd_listen),
        .present (sig_det)
    );

    // {invalid, nibble}
    function automatic logic [4:0] dec5(input logic [4:0] g);
        case (g)
            5'h1e: dec5 = 5'h00;
            5'h09: dec5 = 5'h01;
            5'h14: dec5 = 5'h02;
            5'h15: dec5 = 5'h03;
            5'h0a: dec5 = 5'h04;
            5'h0b: dec5 = 5'h05;
            5'h0e: dec5 = 5'h06;
            5'h0f: dec5 = 5'h07;
            5'h12: dec5 = 5'h08;
            5'h13: dec5 = 5'h09;
            5'h16: dec5 = 5'h0a;
            5'h17: dec5 = 5'h0b;
            5'h1a: dec5 = 5'h0c;
            5'h1b: dec5 = 5'h0d;
            5'h1c: dec5 = 5'h0e;
            5'h1d: dec5 = 5'h0f;
            default: dec5 = {1'b1, `NIB_BAD};
        endcase
    endfunction : dec5

    logic        nrzi_new;
    logic        nrz;
    logic        key;
    logic        d;
    logic [11:0] sr_n;
    logic [4:0]  dg;
    logic [31:0] rv;

    always_comb begin
        nx = st;
        nx.dv = 1'b0;
        nx.er = 1'b0;
        rv = 32'h0;

        nx.tx_nrzi = st.tx_nrzi ^ tx_bit;
        if (nx.tx_nrzi != st.tx_nrzi) begin
            unique case (st.tx_lvl)
                LVL_ZERO: begin
                    nx.tx_lvl = st.tx_last_pos ? LVL_NEG : LVL_POS;
                    nx.tx_last_pos = !st.tx_last_pos;
                end
                LVL_POS: nx.tx_lvl = LVL_ZERO;
                LVL_NEG: nx.tx_lvl = LVL_ZERO;
                default: nx.tx_lvl = LVL_ZERO;
            endcase
        end

        // one recovered symbol per clock, tracked upstream
        nx.rx_prev = rx_level;
        // level to nrzi, nrzi to nrz
        nrzi_new = st.rx_nrzi ^ (rx_level != st.rx_prev);
        nx.rx_nrzi = nrzi_new;
        nrz = nrzi_new ^ st.rx_nrzi;

        // acquire key from idle (plain ones)
        key = st.lfsr[`LFSR_TAP_A] ^ st.lfsr[`LFSR_TAP_B];
        if (!st.locked) begin
            nx.lfsr = {st.lfsr[9:0], !nrz};
            nx.match_cnt = (key == !nrz) ? st.match_cnt + 5'd1 : 5'd0;
            if (key == !nrz && st.match_cnt == 5'(`LOCK_MATCH_BITS - 1)) begin
                nx.locked = 1'b1;
                nx.loss_cnt = '0;
            end
        end else begin
            nx.lfsr = {st.lfsr[9:0], key};
        end
        d = nrz ^ key;
        nx.ones_cnt = d ? (st.ones_cnt == 6'h3f ? st.ones_cnt : st.ones_cnt + 6'd1) : 6'd0;

        if (st.locked) begin
            if (st.ones_cnt >= 6'(`SYNC_IDLE_BITS)) begin
                nx.loss_cnt = '0;
            end else if (st.loss_cnt == SYNC_LOSS_CYC - 16'd1) begin
                nx.locked = 1'b0;
                nx.match_cnt = '0;
            end else begin
                nx.loss_cnt = st.loss_cnt + 16'd1;
            end
        end

        sr_n = {st.sr[10:0], d};
        nx.sr = sr_n;
        dg = dec5(st.prev_grp);
        if (!st.locked) begin
            nx.rst = RX_IDLE;
            nx.pend_pre = 1'b0;
        end else begin
            unique case (st.rst)
                RX_IDLE: begin
                    if (!d && st.ones_cnt >= 6'(`SSD_IDLE_BITS)) begin
                        nx.rst = RX_SSD;
                        nx.bit_cnt = '0;
                    end
                end
                RX_SSD: begin
                    nx.bit_cnt = st.bit_cnt + 3'd1;
                    if (st.bit_cnt == 3'(`SSD_TAIL_BITS - 1)) begin
                        nx.bit_cnt = '0;
                        nx.have_prev = 1'b0;
                        nx.dv = 1'b1;
                        if (sr_n[9:0] == {`CODE_J, `CODE_K}) begin
                            nx.rst = RX_FRAME;
                            nx.nib = `NIB_PRE;
                            nx.pend_pre = 1'b1;
                        end else begin
                            nx.rst = RX_BAD;
                            nx.nib = `NIB_BAD;
                            nx.er = 1'b1;
                            nx.prev_grp = sr_n[4:0];
                        end
                    end
                end
                RX_FRAME: begin
                    nx.bit_cnt = st.bit_cnt + 3'd1;
                    if (st.pend_pre) begin
                        nx.pend_pre = 1'b0;
                        nx.dv = 1'b1;
                        nx.nib = `NIB_PRE;
                    end
                    if (st.bit_cnt == 3'd4) begin
                        nx.bit_cnt = '0;
                        nx.prev_grp = sr_n[4:0];
                        nx.have_prev = 1'b1;
                        if (st.have_prev) begin
                            // end on end pair or two idles
                            if ((st.prev_grp == `CODE_T && sr_n[4:0] == `CODE_R) ||
                                (st.prev_grp == `CODE_I && sr_n[4:0] == `CODE_I)) begin
                                nx.rst = RX_IDLE;
                            end else begin
                                nx.dv = 1'b1;
                                nx.nib = dg[3:0];
                                nx.er = dg[4];
                            end
                        end
                    end
                end
                RX_BAD: begin
                    nx.bit_cnt = st.bit_cnt + 3'd1;
                    if (st.bit_cnt == 3'd4) begin
                        nx.bit_cnt = '0;
                        nx.prev_grp = sr_n[4:0];
                        if (st.prev_grp == `CODE_I && sr_n[4:0] == `CODE_I) begin
                            nx.rst = RX_IDLE;
                        end else begin
                            nx.dv = 1'b1;
                            nx.nib = `NIB_BAD;
                            nx.er = 1'b1;
                        end
                    end
                end
            endcase
        end

        nx.lnk_cnt = st.lnk_cnt + 16'd1;
        unique case (st.lnk)
            LNK_FAIL: begin
                nx.lnk_cnt = '0;
                if (sig_det) begin
                    nx.lnk = LNK_HOLD;
                end
            end
            LNK_HOLD: begin
                if (!sig_det) begin
                    nx.lnk = LNK_FAIL;
                end else if (st.lnk_cnt == LINK_HOLD_CYC - 16'd1) begin
                    nx.lnk = LNK_UP;
                end
            end
            LNK_UP: begin
                nx.lnk_cnt = '0;
                if (st.ctrl[`CTRL_SYNCDN_BIT] && !st.locked) begin
                    nx.lnk = LNK_FAIL;
                end else if (!sig_det) begin
                    nx.lnk = st.ctrl[`CTRL_RECOV_BIT] ? LNK_RECOVER : LNK_FAIL;
                end
            end
            LNK_RECOVER: begin
                if (sig_det) begin
                    nx.lnk = LNK_UP;
                end else if (st.lnk_cnt == RECOVER_CYC - 16'd1) begin
                    nx.lnk = LNK_FAIL;
                end
            end
        endcase
        nx.up = (nx.lnk == LNK_UP) || (nx.lnk == LNK_RECOVER);
        nx.tx_ok = nx.up && nx.locked;

        // register slave: write path
        if (st.rsp.bvalid && s_axi_req.bready) begin
            nx.rsp.bvalid = 1'b0;
        end
        if (s_axi_req.awvalid && st.rsp.awready) begin
            nx.aw_have = 1'b1;
            nx.aw_addr = s_axi_req.awaddr[7:0];
        end
        if (s_axi_req.wvalid && st.rsp.wready) begin
            nx.w_have = 1'b1;
            nx.wdata = s_axi_req.wdata;
            nx.wstrb = s_axi_req.wstrb;
        end
        if (nx.aw_have && nx.w_have && !nx.rsp.bvalid) begin
            nx.aw_have = 1'b0;
            nx.w_have = 1'b0;
            nx.rsp.bvalid = 1'b1;
            nx.rsp.bresp = `RESP_OKAY;
            case (nx.aw_addr)
                `REG_CTRL: if (nx.wstrb[0]) nx.ctrl = nx.wdata[1:0];
                `REG_STATUS: nx.rsp.bresp = `RESP_OKAY;
                `REG_SD_ON: if (nx.wstrb[0]) nx.sd_on = nx.wdata[7:0];
                `REG_SD_OFF: if (nx.wstrb[0]) nx.sd_off = nx.wdata[7:0];
                `REG_SD_LISTEN: begin
                    if (nx.wstrb[0]) nx.sd_listen[7:0] = nx.wdata[7:0];
                    if (nx.wstrb[1]) nx.sd_listen[15:8] = nx.wdata[15:8];
                end
                default: nx.rsp.bresp = `RESP_SLVERR;
            endcase
        end
        nx.rsp.awready = !nx.aw_have && !nx.rsp.bvalid;
        nx.rsp.wready = !nx.w_have && !nx.rsp.bvalid;

        // register slave: read path
        if (st.rsp.rvalid && s_axi_req.rready) begin
            nx.rsp.rvalid = 1'b0;
        end
        if (s_axi_req.arvalid && st.rsp.arready) begin
            nx.rsp.rvalid = 1'b1;
            nx.rsp.rresp = `RESP_OKAY;
            case (s_axi_req.araddr[7:0])
                `REG_CTRL: rv[1:0] = st.ctrl;
                `REG_STATUS: begin
                    rv[`STAT_LOCK_BIT] = st.locked;
                    rv[`STAT_SD_BIT] = sig_det;
                    rv[`STAT_LNK_LSB +: 2] = st.lnk;
                    rv[`STAT_UP_BIT] = st.up;
                    rv[`STAT_FRAME_BIT] = (st.rst == RX_FRAME);
                end
                `REG_SD_ON: rv[7:0] = st.sd_on;
                `REG_SD_OFF: rv[7:0] = st.sd_off;
                `REG_SD_LISTEN: rv[15:0] = st.sd_listen;
                default: nx.rsp.rresp = `RESP_SLVERR;
            endcase
            nx.rsp.rdata = rv;
        end
        nx.rsp.arready = !nx.rsp.rvalid;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
            st.ctrl <= `CTRL_RESET;
            st.sd_on <= `SD_ON_RESET;
            st.sd_off <= `SD_OFF_RESET;
            st.sd_listen <= `SD_LISTEN_RESET;
        end else begin
            st <= nx;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_tx_no_jump: assert property (
        st.tx_lvl != LVL_ZERO |=> st.tx_lvl == $past(st.tx_lvl) || st.tx_lvl == LVL_ZERO)
        else $error("line level jumped between extremes");
    a_tx_one_moves: assert property (
        tx_bit |=> st.tx_lvl != $past(st.tx_lvl)) else $error("one bit did not move level");
    a_tx_zero_holds: assert property (
        !tx_bit |=> $stable(st.tx_lvl)) else $error("zero bit moved level");
    a_rx_off_unlocked: assert property (
        !st.locked |-> !st.tx_ok ##1 !st.dv) else $error("data passed before lock");
    a_pre_pair: assert property (
        st.rst == RX_SSD && nx.rst == RX_FRAME |=> st.dv && st.nib == `NIB_PRE
            ##1 st.dv && st.nib == `NIB_PRE) else $error("preamble pair missing");
    a_ssd_match: assert property (
        st.rst == RX_FRAME && $past(st.rst) == RX_SSD |-> st.sr[9:0] == {`CODE_J, `CODE_K})
        else $error("frame began without start pair");
    a_bad_nibble: assert property (
        st.rst == RX_BAD && st.dv |-> st.nib == `NIB_BAD && st.er) else $error("bad start output");
    a_syncdn_bypass: assert property (
        st.lnk == LNK_UP && !st.ctrl[`CTRL_SYNCDN_BIT] && !st.locked && sig_det
            |=> st.lnk == LNK_UP) else $error("link dropped on sync with option off");
    a_no_recovery: assert property (
        st.lnk == LNK_UP && !st.ctrl[`CTRL_RECOV_BIT] && !sig_det |=> st.lnk == LNK_FAIL)
        else $error("link not failed on energy loss");
    a_bvalid_hold: assert property (
        st.rsp.bvalid && !s_axi_req.bready |=> st.rsp.bvalid) else $error("bvalid dropped");

    c_frame_start: cover property (st.rst == RX_SSD ##1 st.rst == RX_FRAME);
    c_bad_start: cover property (st.rst == RX_SSD ##1 st.rst == RX_BAD);
    c_recover: cover property (st.lnk == LNK_RECOVER ##1 st.lnk == LNK_UP);
    c_lock: cover property ($rose(st.locked));
endmodule : fe_line_codec

// ### fe_line_codec_tb.sv
// self-checking bench for the line coding path
`include "line_defs.svh"
module fe_line_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import line_pkg::*;
    logic        clk = 0;
    logic        resetn = 0;
    logic        tx_bit = 0;
    logic        en = 0;
    logic        up = 1;
    logic [7:0]  rx_energy = 0;
    axi_req_t    req = '0;
    axi_rsp_t    rsp;
    tl_level_t   rx_level, tx_level;
    tl_level_t   exp_lvl = LVL_ZERO;
    logic [3:0]  rx_nibble;
    logic        rx_dv, rx_er, link_up, tx_data_ok;
    integer      seed = 32'hddc12b06;
    logic [31:0] d, n, v;
    logic [1:0]  r;
    logic [4:0]  got[$], exq[$];
    logic [4:0]  enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    int          fail_count = 0;
    int          samples_checked = 0;
    fe_line_codec #(.SYNC_LOSS_CYC(16'h00c8), .LINK_HOLD_CYC(16'h0014),
                    .RECOVER_CYC(16'h000a)) u_dut (
        .clk(clk), .resetn(resetn), .s_axi_req(req), .s_axi_rsp(rsp),
        .tx_bit(tx_bit), .rx_level(rx_level), .rx_energy(rx_energy),
        .tx_level(tx_level), .rx_nibble(rx_nibble), .rx_dv(rx_dv), .rx_er(rx_er),
        .link_up(link_up), .tx_data_ok(tx_data_ok));
    lp_model u_lp (.clk(clk), .rx_level(rx_level));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        req.awvalid <= 1;
        req.awaddr <= {24'h0, a};
        req.wvalid <= 1;
        req.wdata <= x;
        req.wstrb <= 4'hf;
        req.bready <= 1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 0;
            if (rsp.wready) req.wvalid <= 0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req.arvalid <= 1;
        req.araddr <= {24'h0, a};
        req.rready <= 1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 0;
        end while (rsp.rvalid !== 1'b1);
        v = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a);
        chk("rdata", e, v);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rc
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (!resetn) begin
            exp_lvl <= LVL_ZERO;
            up <= 1;
        end else if (tx_bit && exp_lvl != LVL_ZERO) begin
            exp_lvl <= LVL_ZERO;
            up <= ~up;
        end else if (tx_bit) begin
            exp_lvl <= up ? LVL_POS : LVL_NEG;
        end
        d = $random(seed);
        tx_bit <= d[7];
        rx_energy <= en ? {1'b1, d[6:0]} : {3'h0, d[4:0]};
        if (rx_dv === 1'b1) got.push_back({rx_er, rx_nibble});
    end
    always @(negedge clk) chk("tx_level", exp_lvl, tx_level);
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        #1 chk("tx_data_ok", 0, tx_data_ok);
        rc(`REG_CTRL, 0, `RESP_OKAY);
        rc(`REG_SD_ON, `SD_ON_RESET, `RESP_OKAY);
        rc(`REG_SD_OFF, `SD_OFF_RESET, `RESP_OKAY);
        rc(8'h20, 0, `RESP_SLVERR);
        wr(`REG_SD_LISTEN, 32'h2);
        rc(`REG_SD_LISTEN, 32'h2, `RESP_OKAY);
        en <= 1;
        for (int i = 0; i < 900 && !(link_up && tx_data_ok); i++) @(posedge clk);
        rc(`REG_STATUS, 32'h1b, `RESP_OKAY);
        for (int f = 0; f < 2; f++) begin
            got.delete();
            exq = '{5'h05, 5'h05};
            u_lp.send(`CODE_J);
            u_lp.send(`CODE_K);
            repeat (8) begin
                n = $random(seed);
                u_lp.send(enc[n[3:0]]);
                exq.push_back({1'b0, n[3:0]});
            end
            if (f == 0) u_lp.send(`CODE_T);
            if (f == 0) u_lp.send(`CODE_R);
            repeat (120) @(posedge clk);
            chk("count", exq.size(), got.size());
            foreach (exq[i]) chk("nibble", exq[i], got[i]);
        end
        got.delete();
        u_lp.send(enc[0]);
        repeat (60) @(posedge clk);
        chk("bad start", 5'h1e, got[0]);
        rc(`REG_STATUS, 32'h1b, `RESP_OKAY);
        // data with no idle run outlasts the sync check: lock drops, link stays up
        repeat (50) u_lp.send(enc[0]);
        for (int i = 0; i < 400 && tx_data_ok !== 1'b0; i++) @(posedge clk);
        chk("sync loss", 0, tx_data_ok);
        chk("bypass link_up", 1, link_up);
        for (int i = 0; i < 400 && tx_data_ok !== 1'b1; i++) @(posedge clk);
        chk("relock", 1, tx_data_ok);
        wr(`REG_CTRL, 32'h3);
        rc(`REG_CTRL, 32'h3, `RESP_OKAY);
        // with the add-on enabled the same loss takes the link down
        repeat (50) u_lp.send(enc[0]);
        for (int i = 0; i < 400 && link_up !== 1'b0; i++) @(posedge clk);
        chk("sync drop link_up", 0, link_up);
        for (int i = 0; i < 400 && !(link_up && tx_data_ok); i++) @(posedge clk);
        chk("relink", 1, tx_data_ok);
        en <= 0;
        for (int i = 0; i < 900 && link_up !== 1'b0; i++) @(posedge clk);
        rd(`REG_STATUS);
        chk("status", 0, v[4:1]);
        end_sim();
    end
endmodule : fe_line_codec_tb

// ### line_defs.svh
// register map, field positions, reset values, code-groups and timing counts
`ifndef LINE_DEFS_SVH
`define LINE_DEFS_SVH
`define CLK_MHZ           40
`define US_TO_CYC(t)      ((t) * `CLK_MHZ)
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_SD_ON         8'h08
`define REG_SD_OFF        8'h0c
`define REG_SD_LISTEN     8'h10
`define CTRL_RECOV_BIT    0
`define CTRL_SYNCDN_BIT   1
`define CTRL_RESET        2'h0
`define STAT_LOCK_BIT     0
`define STAT_SD_BIT       1
`define STAT_LNK_LSB      2
`define STAT_UP_BIT       4
`define STAT_FRAME_BIT    5
`define SD_ON_RESET       8'h40
`define SD_OFF_RESET      8'h20
`define SD_LISTEN_RESET   16'h0010
`define SD_IIR_SHIFT      3
`define LOCK_MATCH_BITS   30
`define SYNC_IDLE_BITS    60
`define SSD_IDLE_BITS     12
`define SSD_TAIL_BITS     7
`define SYNC_LOSS_US      722
`define LINK_HOLD_US      50
`define RECOVER_US        10
`define LFSR_TAP_A        10
`define LFSR_TAP_B        8
`define CODE_J            5'h18
`define CODE_K            5'h11
`define CODE_T            5'h0d
`define CODE_R            5'h07
`define CODE_I            5'h1f
`define NIB_PRE           4'h5
`define NIB_BAD           4'he
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ### line_pkg.sv
// types shared by the line coding path and its register slave
package line_pkg;
    typedef enum logic [1:0] {LVL_ZERO, LVL_POS, LVL_NEG} tl_level_t;
    typedef enum logic [1:0] {RX_IDLE, RX_SSD, RX_FRAME, RX_BAD} rx_state_t;
    typedef enum logic [1:0] {LNK_FAIL, LNK_HOLD, LNK_UP, LNK_RECOVER} link_state_t;
    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axi_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;
endpackage : line_pkg

// ### lp_model.sv
// far-end transceiver model: scrambler, nrzi and three-level line code
module lp_model (
    input  wire logic           clk,
    output line_pkg::tl_level_t rx_level = line_pkg::LVL_ZERO
);
    timeunit 1ns;
    timeprecision 1ps;
    import line_pkg::*;
    logic [10:0] lfsr = 11'h7ff;
    logic        up = 1'b1;
    logic        k, s;
    logic        q[$];
    task automatic send(input logic [4:0] g);
        for (int i = 4; i >= 0; i--) q.push_back(g[i]);
    endtask : send
    // idle ones go out whenever no group is queued; a one moves the level, a zero holds it
    always @(posedge clk) begin
        k = lfsr[10] ^ lfsr[8];
        s = ((q.size() > 0) ? q.pop_front() : 1'b1) ^ k;
        lfsr = {lfsr[9:0], k};
        if (s && rx_level != LVL_ZERO) begin
            rx_level <= LVL_ZERO;
            up = ~up;
        end else if (s) begin
            rx_level <= up ? LVL_POS : LVL_NEG;
        end
    end
endmodule : lp_model

// ### sig_energy_detect.sv
// signal detect from an iir-filtered energy measure with hysteresis
`include "line_defs.svh"
module sig_energy_detect #(
    parameter int W  = 8,
    parameter int K  = `SD_IIR_SHIFT,
    parameter int LW = 16
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic [W-1:0]  energy,
    input  wire logic [W-1:0]  on_thr,
    input  wire logic [W-1:0]  off_thr,
    input  wire logic [LW-1:0] listen,
    output logic               present
);
    import line_pkg::*;
    typedef struct packed {
        logic [W+K-1:0] acc;
        logic [LW-1:0]  cnt;
        logic           det;
    } sd_st_t;
    sd_st_t st;
    sd_st_t nx;
    logic [W-1:0] filt;
    assign filt = st.acc[W+K-1:K];
    assign present = st.det;

    always_comb begin
        nx = st;
        nx.acc = st.acc + (W+K)'(energy) - (st.acc >> K);
        if ((!st.det && filt >= on_thr) || (st.det && filt < off_thr)) begin
            nx.cnt = st.cnt + LW'(1);
            if (st.cnt >= listen) begin
                nx.det = !st.det;
                nx.cnt = '0;
            end
        end else begin
            nx.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    a_sd_hold_on: assert property (@(posedge clk) disable iff (!resetn)
        st.det && filt >= off_thr |=> st.det) else $error("detect dropped above off level");
    a_sd_stay_off: assert property (@(posedge clk) disable iff (!resetn)
        !st.det && filt < on_thr |=> !st.det) else $error("detect rose below on level");
    c_sd_rise: cover property (@(posedge clk) disable iff (!resetn) $rose(st.det));
endmodule : sig_energy_detect
